// *** pfci_host.sv ***
/*
 * Host controller for an 8-bit parallel NOR flash. It turns single user
 * requests into the bus write sequences the flash command decoder expects,
 * and performs plain and signature reads.
 * Assumes the flash pins are joined by the surrounding logic: the data pins
 * are resolved from data_oe, and the flash data comes back on flash_data_in.
 */
//
// Summary of operation
// - Return-to-read: one F0, or three-write form.
// - Identification entry: AA/555, 55/2AA, 90/555.
// - Program: unlock, A0/555, then target byte.
// - Bypass entry: unlock then 20/555.
// - Bypass program: A0 anywhere, then target byte.
// - Chip erase is six-write sequence ending 10/555.
// - Block erase adds blocks within 50 us.
// - Suspend writes B0, resume writes 30.
`default_nettype none

module pfci_host #(
   parameter int BLK_WIN_CYC = pfci_pkg::BLK_WIN_CYC
) (
   // Clock and reset.
   input wire logic sys_clk,
   input wire logic nrst,
   // User request port.
   input wire logic req_valid,
   input wire pfci_pkg::pfci_req_t req,
   output logic req_ready,
   // User answer port.
   output logic done,
   output logic [7:0] rdata,
   output logic blk_window,
   // Flash pins.
   output pfci_pkg::pfci_pins_t pins,
   input wire logic [7:0] flash_data_in
);

   ////////////////////////////////////////////////////////////////////////////
   // Command tables.

   // Number of bus writes an operation needs; reads need none.
   function automatic logic [2:0] cmd_len(input pfci_pkg::pfci_op_t op);
      case (op)
         pfci_pkg::OP_RESET1, pfci_pkg::OP_BLK_ADD, pfci_pkg::OP_SUSPEND, pfci_pkg::OP_RESUME: cmd_len = 3'h1;
         pfci_pkg::OP_BYP_PROG, pfci_pkg::OP_BYP_EXIT: cmd_len = 3'h2;
         pfci_pkg::OP_RESET3, pfci_pkg::OP_IDENT, pfci_pkg::OP_BYPASS: cmd_len = 3'h3;
         pfci_pkg::OP_PROGRAM: cmd_len = 3'h4;
         pfci_pkg::OP_CHIP_ERASE, pfci_pkg::OP_BLK_ERASE: cmd_len = 3'h6;
         default: cmd_len = 3'h0;
      endcase
   endfunction : cmd_len

   // Address and data of write number idx of an operation.
   function automatic pfci_pkg::pfci_word_t cmd_word(input pfci_pkg::pfci_op_t op, input logic [2:0] idx,
                                                     input logic [18:0] ua, input logic [7:0] ud);
      pfci_pkg::pfci_word_t w;
      logic erase;
      // Don't-care addresses carry the user address; upper bits never matter.
      w.addr = ua;
      w.data = ud;
      erase = (op == pfci_pkg::OP_CHIP_ERASE) || (op == pfci_pkg::OP_BLK_ERASE);
      case (op)
         pfci_pkg::OP_RESET1: w.data = pfci_pkg::CODE_RESET;
         pfci_pkg::OP_BYP_PROG: if (idx == 3'h0) w.data = pfci_pkg::CODE_PROG;
         pfci_pkg::OP_BYP_EXIT: w.data = (idx == 3'h0) ? pfci_pkg::CODE_IDENT : pfci_pkg::CODE_BYP_EXIT;
         pfci_pkg::OP_BLK_ADD: w.data = pfci_pkg::CODE_BLK_ERASE;
         pfci_pkg::OP_SUSPEND: w.data = pfci_pkg::CODE_SUSPEND;
         pfci_pkg::OP_RESUME: w.data = pfci_pkg::CODE_RESUME;
         default: begin
            // Sequences opened by the two unlock writes.
            if (idx == 3'h0 || (idx == 3'h3 && erase)) begin
               w = '{addr: pfci_pkg::UNLOCK1_ADDR, data: pfci_pkg::CODE_UNLOCK1};
            end else if (idx == 3'h1 || idx == 3'h4) begin
               w = '{addr: pfci_pkg::UNLOCK2_ADDR, data: pfci_pkg::CODE_UNLOCK2};
            end else if (idx == 3'h2) begin
               w.addr = pfci_pkg::UNLOCK1_ADDR;
               case (op)
                  pfci_pkg::OP_RESET3: w.data = pfci_pkg::CODE_RESET;
                  pfci_pkg::OP_IDENT: w.data = pfci_pkg::CODE_IDENT;
                  pfci_pkg::OP_PROGRAM: w.data = pfci_pkg::CODE_PROG;
                  pfci_pkg::OP_BYPASS: w.data = pfci_pkg::CODE_BYPASS;
                  default: w.data = pfci_pkg::CODE_ERASE_PRE;
               endcase
            end else if (idx == 3'h5) begin
               if (op == pfci_pkg::OP_CHIP_ERASE) begin
                  w = '{addr: pfci_pkg::UNLOCK1_ADDR, data: pfci_pkg::CODE_CHIP_ERASE};
               end else begin
                  w.data = pfci_pkg::CODE_BLK_ERASE;
               end
            end
            // Program write four keeps the target address and value.
         end
      endcase
      return w;
   endfunction : cmd_word

   ////////////////////////////////////////////////////////////////////////////
   // State.

   // Registered state and its next value.
   pfci_pkg::pfci_state_t s_q;
   pfci_pkg::pfci_state_t s_d;
   // Word for the next write while stepping through a sequence.
   pfci_pkg::pfci_word_t nxt_w;
   // Word for the first write of a new request.
   pfci_pkg::pfci_word_t req_w;

   // New requests wait for idle and for any abort time to run out.
   assign req_ready = (s_q.st == pfci_pkg::ST_IDLE) && (s_q.abort_cnt == 16'h0000);
   assign done = s_q.done;
   assign rdata = s_q.rdata;
   assign blk_window = (s_q.win_cnt != 16'h0000);
   assign pins = s_q.pins;
   assign nxt_w = cmd_word(s_q.op, 3'(s_q.idx + 3'h1), s_q.ua, s_q.ud);
   assign req_w = cmd_word(req.op, 3'h0, req.addr, req.data);

   ////////////////////////////////////////////////////////////////////////////
   // Next-state logic.

   // Sequences bus writes and reads; one write per pass of setup, low and hold.
   always_comb begin
      s_d = s_q;
      s_d.done = 1'b0;
      // Data pins are asynchronous: two stages before use.
      s_d.sync1 = flash_data_in;
      s_d.sync2 = s_q.sync1;
      if (s_q.abort_cnt != 16'h0000) begin
         s_d.abort_cnt = s_q.abort_cnt - 16'h0001;
      end
      if (s_q.win_cnt != 16'h0000) begin
         s_d.win_cnt = s_q.win_cnt - 16'h0001;
      end
      case (s_q.st)
         pfci_pkg::ST_IDLE: begin
            if (req_valid && req_ready) begin
               s_d.op = req.op;
               s_d.ua = req.addr;
               s_d.ud = req.data;
               s_d.idx = 3'h0;
               if (req.op == pfci_pkg::OP_READ || req.op == pfci_pkg::OP_SIG_READ) begin
                  // Read: chip on and read drive low, store strobe high.
                  s_d.pins.addr = req.addr;
                  s_d.pins.chip_on_n = 1'b0;
                  s_d.pins.read_drive_n = 1'b0;
                  s_d.pins.signature_hv_level = (req.op == pfci_pkg::OP_SIG_READ);
                  s_d.cnt = 16'(pfci_pkg::RD_CYC + pfci_pkg::SYNC_STAGES - 1);
                  s_d.st = pfci_pkg::ST_RD;
               end else if (req.op == pfci_pkg::OP_BLK_ADD && s_q.win_cnt == 16'h0000) begin
                  // Window closed: extra block is refused with no bus write.
                  s_d.done = 1'b1;
               end else begin
                  s_d.pins.addr = req_w.addr;
                  s_d.pins.data = req_w.data;
                  s_d.pins.data_oe = 1'b1;
                  s_d.pins.chip_on_n = 1'b0;
                  s_d.st = pfci_pkg::ST_SETUP;
               end
            end
         end
         pfci_pkg::ST_SETUP: begin
            // Address and data settled: drop the store strobe.
            s_d.pins.store_strobe_n = 1'b0;
            s_d.cnt = 16'(pfci_pkg::WR_CYC - 1);
            s_d.st = pfci_pkg::ST_WR_LOW;
         end
         pfci_pkg::ST_WR_LOW: begin
            if (s_q.cnt == 16'h0000) begin
               // Rising strobe completes the write; data held one more cycle.
               s_d.pins.store_strobe_n = 1'b1;
               s_d.st = pfci_pkg::ST_HOLD;
            end else begin
               s_d.cnt = s_q.cnt - 16'h0001;
            end
         end
         pfci_pkg::ST_HOLD: begin
            s_d.pins.data_oe = 1'b0;
            s_d.pins.chip_on_n = 1'b1;
            if (s_q.idx == 3'(cmd_len(s_q.op) - 3'h1)) begin
               s_d.done = 1'b1;
               s_d.st = pfci_pkg::ST_IDLE;
               case (s_q.op)
                  // The device may need its abort time after these.
                  pfci_pkg::OP_RESET1, pfci_pkg::OP_RESET3, pfci_pkg::OP_BYP_EXIT:
                     s_d.abort_cnt = 16'(pfci_pkg::ABORT_CYC);
                  // Each selected block restarts the add window.
                  pfci_pkg::OP_BLK_ERASE, pfci_pkg::OP_BLK_ADD: s_d.win_cnt = 16'(BLK_WIN_CYC);
                  // No further blocks once suspended.
                  pfci_pkg::OP_SUSPEND: s_d.win_cnt = 16'h0000;
                  default: s_d.st = pfci_pkg::ST_IDLE;
               endcase
            end else begin
               s_d.st = pfci_pkg::ST_GAP;
            end
         end
         pfci_pkg::ST_GAP: begin
            // Chip on was high for a cycle; start the next write.
            s_d.idx = 3'(s_q.idx + 3'h1);
            s_d.pins.addr = nxt_w.addr;
            s_d.pins.data = nxt_w.data;
            s_d.pins.data_oe = 1'b1;
            s_d.pins.chip_on_n = 1'b0;
            s_d.st = pfci_pkg::ST_SETUP;
         end
         pfci_pkg::ST_RD: begin
            if (s_q.cnt == 16'h0000) begin
               // Status, codes or array data, whatever the device presents.
               s_d.rdata = s_q.sync2;
               s_d.done = 1'b1;
               s_d.pins = pfci_pkg::PINS_IDLE;
               s_d.st = pfci_pkg::ST_IDLE;
            end else begin
               s_d.cnt = s_q.cnt - 16'h0001;
            end
         end
         default: s_d.st = pfci_pkg::ST_IDLE;
      endcase
   end

   // State register with synchronous reset.
   always_ff @(posedge sys_clk) begin
      if (!nrst) begin
         s_q <= '{st: pfci_pkg::ST_IDLE, op: pfci_pkg::OP_READ, pins: pfci_pkg::PINS_IDLE, default: '0};
      end else begin
         s_q <= s_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Assertions.

   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!nrst);

   // Write edge of the current step: first cycle of the store strobe low time.
   logic wr_edge;
   assign wr_edge = (s_q.st == pfci_pkg::ST_WR_LOW) && (s_q.cnt == 16'(pfci_pkg::WR_CYC - 1));

   a_strobe_excl: assert property (!(!pins.store_strobe_n && !pins.read_drive_n))
      else $error("store and read strobes low together");
   a_drive_no_read: assert property (pins.data_oe |-> pins.read_drive_n && !pins.chip_on_n)
      else $error("data driven outside a write");
   a_wr_pulse_len: assert property (wr_edge |-> !pins.store_strobe_n [*4] ##1 pins.store_strobe_n)
      else $error("store strobe low time wrong");
   a_first_unlock: assert property (wr_edge && s_q.idx == 3'h0 && cmd_len(s_q.op) >= 3'h3
      |-> pins.addr == pfci_pkg::UNLOCK1_ADDR && pins.data == pfci_pkg::CODE_UNLOCK1)
      else $error("first unlock write wrong");
   a_second_unlock: assert property (wr_edge && s_q.idx == 3'h1 && cmd_len(s_q.op) >= 3'h3
      |-> pins.addr == pfci_pkg::UNLOCK2_ADDR && pins.data == pfci_pkg::CODE_UNLOCK2)
      else $error("second unlock write wrong");
   a_prog_target: assert property (wr_edge && s_q.op == pfci_pkg::OP_PROGRAM && s_q.idx == 3'h3
      |-> pins.addr == s_q.ua && pins.data == s_q.ud)
      else $error("program target write wrong");
   a_bypass_prog: assert property (wr_edge && s_q.op == pfci_pkg::OP_BYP_PROG && s_q.idx == 3'h0
      |-> pins.data == pfci_pkg::CODE_PROG)
      else $error("bypass program code wrong");
   a_chip_erase_end: assert property (wr_edge && s_q.op == pfci_pkg::OP_CHIP_ERASE && s_q.idx == 3'h5
      |-> pins.addr == pfci_pkg::UNLOCK1_ADDR && pins.data == pfci_pkg::CODE_CHIP_ERASE)
      else $error("chip erase final write wrong");
   a_window_start: assert property (done && s_q.op == pfci_pkg::OP_BLK_ERASE |-> blk_window)
      else $error("block add window not opened");
   a_suspend_code: assert property (wr_edge && s_q.op == pfci_pkg::OP_SUSPEND |-> pins.data == pfci_pkg::CODE_SUSPEND)
      else $error("suspend code wrong");
   a_abort_hold: assert property (done && s_q.op == pfci_pkg::OP_RESET1 |-> !req_ready [*8])
      else $error("request accepted during abort time");

   c_program: cover property (done && s_q.op == pfci_pkg::OP_PROGRAM);
   c_block_add: cover property (done && s_q.op == pfci_pkg::OP_BLK_ADD && blk_window);
   c_sig_read: cover property (done && s_q.op == pfci_pkg::OP_SIG_READ);
   c_reset3: cover property (done && s_q.op == pfci_pkg::OP_RESET3);

endmodule : pfci_host

`default_nettype wire

// *** pfci_pkg.sv ***
/*
 * Shared definitions for the parallel flash command host: timing counts,
 * command codes, unlock addresses, the request carrier, the pin bundle and
 * the state record of the host controller.
 * Assumes a 100 MHz system clock and an 8-bit flash with a 19-bit address bus.
 */
`default_nettype none

package pfci_pkg;

   ////////////////////////////////////////////////////////////////////////////
   // Timing.

   // System clock period in nanoseconds.
   localparam int CLK_PERIOD_NS = 10;
   // Least time the store strobe is held low on a bus write.
   localparam int WR_LOW_NS = 40;
   // Least time from read drive low to valid data on the pins.
   localparam int RD_ACC_NS = 60;
   // Stages of the input synchroniser on the data pins.
   localparam int SYNC_STAGES = 2;
   // Time the device may take to abort after a return-to-read command.
   localparam int ABORT_US = 10;
   // Window for adding another block to a block erase.
   localparam int BLK_WIN_US = 50;
   // Derived cycle counts; least times round up.
   localparam int WR_CYC = (WR_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int RD_CYC = (RD_ACC_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int ABORT_CYC = (ABORT_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   // Longest time rounds down; used as the default of a module parameter.
   localparam int BLK_WIN_CYC = (BLK_WIN_US * 1000) / CLK_PERIOD_NS;

   ////////////////////////////////////////////////////////////////////////////
   // Command addresses and codes.

   localparam logic [18:0] UNLOCK1_ADDR = 19'h00555;
   localparam logic [18:0] UNLOCK2_ADDR = 19'h002aa;
   localparam logic [7:0] CODE_UNLOCK1 = 8'haa;
   localparam logic [7:0] CODE_UNLOCK2 = 8'h55;
   localparam logic [7:0] CODE_RESET = 8'hf0;
   localparam logic [7:0] CODE_IDENT = 8'h90;
   localparam logic [7:0] CODE_PROG = 8'ha0;
   localparam logic [7:0] CODE_BYPASS = 8'h20;
   localparam logic [7:0] CODE_BYP_EXIT = 8'h00;
   localparam logic [7:0] CODE_ERASE_PRE = 8'h80;
   localparam logic [7:0] CODE_CHIP_ERASE = 8'h10;
   localparam logic [7:0] CODE_BLK_ERASE = 8'h30;
   localparam logic [7:0] CODE_SUSPEND = 8'hb0;
   localparam logic [7:0] CODE_RESUME = 8'h30;

   ////////////////////////////////////////////////////////////////////////////
   // Types.

   // Operations the user may request.
   typedef enum logic [3:0] {
      OP_READ, OP_SIG_READ, OP_RESET1, OP_RESET3, OP_IDENT, OP_PROGRAM, OP_BYPASS,
      OP_BYP_PROG, OP_BYP_EXIT, OP_CHIP_ERASE, OP_BLK_ERASE, OP_BLK_ADD, OP_SUSPEND, OP_RESUME
   } pfci_op_t;

   // One user request.
   typedef struct packed {
      pfci_op_t op;
      logic [18:0] addr;
      logic [7:0] data;
   } pfci_req_t;

   // One bus write word.
   typedef struct packed {
      logic [18:0] addr;
      logic [7:0] data;
   } pfci_word_t;

   // Pins driven towards the flash.
   typedef struct packed {
      logic [18:0] addr;
      logic [7:0] data;
      logic data_oe;
      logic chip_on_n;
      logic read_drive_n;
      logic store_strobe_n;
      logic signature_hv_level;
   } pfci_pins_t;

   // Sequencer states.
   typedef enum logic [2:0] {ST_IDLE, ST_SETUP, ST_WR_LOW, ST_HOLD, ST_GAP, ST_RD} pfci_st_t;

   // Complete state of the host.
   typedef struct packed {
      pfci_st_t st;
      pfci_op_t op;
      logic [18:0] ua;
      logic [7:0] ud;
      logic [2:0] idx;
      logic [15:0] cnt;
      logic [15:0] abort_cnt;
      logic [15:0] win_cnt;
      logic [7:0] sync1;
      logic [7:0] sync2;
      logic [7:0] rdata;
      logic done;
      pfci_pins_t pins;
   } pfci_state_t;

   // Pins at rest: bus released, strobes high.
   localparam pfci_pins_t PINS_IDLE = '{addr: 19'h00000, data: 8'h00, data_oe: 1'b0, chip_on_n: 1'b1,
                                        read_drive_n: 1'b1, store_strobe_n: 1'b1, signature_hv_level: 1'b0};

endpackage : pfci_pkg

`default_nettype wire

// *** pfci_flash_model.sv ***
/*
 * Behavioural flash device for the host bench: command decoder, sparse array,
 * identification codes, block protection flags and a busy period after each change.
 * Assumes the pins come straight from pfci_host and flash_data_in goes back to it.
 */
`default_nettype none

module pfci_flash_model #(
   parameter logic [7:0] MAKER_CODE = 8'h3c, // Arbitrary value.
   parameter logic [7:0] PART_CODE = 8'hc3, // Arbitrary value.
   parameter logic [7:0] PROT = 8'h08, // One protection flag per block.
   parameter logic [7:0] STATUS_VAL = 8'h4c, // Byte shown while busy.
   parameter int BUSY_NS = 3000 // Length of a program or erase.
) (
   // Pins from the host.
   input wire pfci_pkg::pfci_pins_t pins,
   // Data pins as the host sees them.
   output wire logic [7:0] flash_data_in
);
   timeunit 1ns;
   timeprecision 1ps;

   ////////////////////////////////////////////////////////////////////////////
   logic [7:0] mem [int]; // Sparse array; absent bytes read as erased.
   int step = 0; // Position in a normal command sequence.
   int bstep = 0; // Position in a bypass command sequence.
   int mode = 0; // Array read 0, identification 1, bypass 2.
   int nwr = 0; // Bus writes seen.
   int viol = 0; // Pin protocol breaches seen.
   bit eadd = 1'b0; // Block erase still takes further blocks.
   bit susp = 1'b0; // Erase suspended while blocks could still be added.
   time busy_end = 0; // End of the running program or erase.
   logic [7:0] q;
   logic [7:0] last = 8'h00;

   // Value a bus read returns in the present mode.
   function automatic logic [7:0] rdval(input logic [18:0] a);
      if (pins.signature_hv_level) return a[0] ? PART_CODE : MAKER_CODE;
      if ($time < busy_end) return STATUS_VAL;
      if (mode == 1) return a[1] ? {7'h00, PROT[a[18:16]]} : (a[0] ? PART_CODE : MAKER_CODE);
      return mem.exists(a) ? mem[a] : 8'hff;
   endfunction : rdval

   // Programs one byte unless its block is protected.
   task automatic prog(input logic [18:0] a, input logic [7:0] d);
      if (PROT[a[18:16]]) return; // Silently ignored, no status shown.
      mem[a] = (mem.exists(a) ? mem[a] : 8'hff) & d; // Programming only clears bits.
      busy_end = $time + BUSY_NS;
      mode = 0;
   endtask : prog

   // Erases one block, or every block when blk is negative; protected ones stay.
   task automatic erase(input int blk);
      foreach (mem[k]) if ((blk < 0 || k[18:16] == blk) && !PROT[k[18:16]]) mem[k] = 8'hff;
      busy_end = $time + BUSY_NS;
      mode = 0; // An erase ends identification mode; array read follows completion.
   endtask : erase

   // Command decoder, advanced once per completed bus write.
   task automatic wr(input logic [18:0] a, input logic [7:0] d);
      logic u1;
      logic u2;
      u1 = a[10:0] == 11'h555; // Only the low eleven bits are compared.
      u2 = a[10:0] == 11'h2aa;
      nwr++;
      if ($time < busy_end && !eadd) return; // A running operation ignores commands, except a block erase that still takes blocks.
      if (mode == 2) begin // Bypass takes only its program and exit.
         if (bstep == 1) prog(a, d);
         else if (bstep == 2 && d == 8'h00) mode = 0;
         if (mode == 0 && bstep == 1) mode = 2;
         bstep = (d == 8'ha0 && bstep == 0) ? 1 : (d == 8'h90 && bstep != 1) ? 2 : 0;
         return;
      end
      if (eadd && (d == 8'h30 || d == 8'hb0)) begin // Added block, suspend or resume.
         if (d == 8'h30 && !susp) erase(int'(a[18:16]));
         else if (d == 8'h30) eadd = 1'b0; // Resume: no more blocks may be added.
         susp = d == 8'hb0;
         return;
      end
      eadd = 1'b0;
      if (step == 3) begin
         prog(a, d);
         step = 0;
      end else if (d == 8'hf0) begin // Return to read, one or three writes.
         mode = 0;
         step = 0;
      end else if ((step == 0 || step == 4) && u1 && d == 8'haa) step++;
      else if ((step == 1 || step == 5) && u2 && d == 8'h55) step++;
      else if (step == 2 && u1 && d == 8'ha0) step = 3;
      else if (step == 2 && u1 && d == 8'h80) step = 4;
      else if (step == 2 && u1 && (d == 8'h90 || d == 8'h20)) begin
         mode = (d == 8'h90) ? 1 : 2;
         step = 0;
      end else if (step == 6 && ((u1 && d == 8'h10) || d == 8'h30)) begin
         erase((d == 8'h10) ? -1 : int'(a[18:16]));
         eadd = d == 8'h30;
         step = 0;
      end else begin // A broken sequence falls back to array read.
         mode = 0;
         step = 0;
      end
   endtask : wr

   ////////////////////////////////////////////////////////////////////////////
   // A write strobe needs chip on, read drive off and driven data pins.
   always @(negedge pins.store_strobe_n) if (pins.chip_on_n || !pins.read_drive_n || !pins.data_oe) viol++;

   // Data is latched on the rising store strobe.
   always @(posedge pins.store_strobe_n) if (!pins.chip_on_n) wr(pins.addr, pins.data);

   // Read drive; released pins show the inverse of the last value, never a held one.
   always @* begin
      if (!pins.chip_on_n && !pins.read_drive_n && pins.store_strobe_n) begin
         q = rdval(pins.addr);
         last = q;
      end else q = ~last;
   end

   // Whoever drives the pins wins; the device answers after its access time.
   assign #40 flash_data_in = pins.data_oe ? pins.data : q;
endmodule : pfci_flash_model

`default_nettype wire

// *** tb.sv ***
/*
 * Self-checking bench: pfci_host drives the behavioural flash model.
 * Assumes pfci_pkg, pfci_host and pfci_flash_model are compiled first.
 */
`default_nettype none

module tb;
   timeunit 1ns;
   timeprecision 1ps;
   localparam logic [7:0] MAKER = 8'h3c; // Arbitrary value.
   localparam logic [7:0] PART = 8'hc3; // Arbitrary value.
   localparam logic [7:0] STAT = 8'h4c; // Busy status byte of the model.
   logic sys_clk = 1'b0;
   logic nrst = 1'b0;
   logic req_valid = 1'b0;
   pfci_pkg::pfci_req_t req = '0;
   logic req_ready;
   logic done;
   logic blk_window;
   logic [7:0] rdata;
   logic [7:0] flash_data_in;
   logic [7:0] got; // Result of the last request.
   pfci_pkg::pfci_pins_t pins;
   int n_errors = 0;
   int check_count = 0;
   int w0;

   pfci_host #(.BLK_WIN_CYC(50)) pfci_host_i (.sys_clk(sys_clk), .nrst(nrst), .req_valid(req_valid), .req(req),
      .req_ready(req_ready), .done(done), .rdata(rdata), .blk_window(blk_window), .pins(pins),
      .flash_data_in(flash_data_in));
   pfci_flash_model #(.MAKER_CODE(MAKER), .PART_CODE(PART), .STATUS_VAL(STAT)) pfci_flash_model_i (.pins(pins),
      .flash_data_in(flash_data_in));

   // 100 MHz clock.
   always #5 sys_clk = ~sys_clk;

   ////////////////////////////////////////////////////////////////////////////
   // Prints the counts and the verdict, then ends the run.
   task automatic test_done();
      $display("Checks %0d, mismatches %0d", check_count, n_errors);
      if (n_errors == 0 && check_count > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask : test_done

   // Compares a seen value with the expected one.
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      check_count++;
      if (seen !== exp) begin
         n_errors++;
         $display("Error at %0t: seen %0h expected %0h", $time, seen, exp);
      end
   endtask : chk

   // Moves to just after the next rising edge.
   task automatic tick();
      @(posedge sys_clk);
      #1;
   endtask : tick

   // Holds one request until taken, then waits for its done pulse.
   task automatic run(input pfci_pkg::pfci_op_t op, input logic [18:0] a, input logic [7:0] d);
      int n;
      tick();
      req_valid = 1'b1;
      req = '{op: op, addr: a, data: d};
      n = 0;
      while (req_ready !== 1'b1) begin
         tick();
         if (++n > 3000) test_fail();
      end
      tick();
      req_valid = 1'b0;
      n = 0;
      while (done !== 1'b1) begin
         tick();
         if (++n > 300) test_fail();
      end
      got = rdata;
   endtask : run

   // A bound that ran out counts as a mismatch.
   task automatic test_fail();
      n_errors++;
      test_done();
   endtask : test_fail

   // Reads until the busy status gives way.
   task automatic poll(input logic [18:0] a);
      int n;
      n = 0;
      do begin
         run(pfci_pkg::OP_READ, a, 8'h00);
         if (++n > 100) test_fail();
      end while (got === STAT);
   endtask : poll

   ////////////////////////////////////////////////////////////////////////////
   task automatic t_ident();
      chk({pins.chip_on_n, pins.read_drive_n, pins.store_strobe_n, pins.data_oe, req_ready, done}, 6'h3a);
      run(pfci_pkg::OP_IDENT, 19'h00000, 8'h00);
      run(pfci_pkg::OP_READ, 19'h7fffc, 8'h00);
      chk(got, MAKER);
      run(pfci_pkg::OP_READ, 19'h4abc1, 8'h00);
      chk(got, PART);
      run(pfci_pkg::OP_READ, 19'h35552, 8'h00);
      chk(got, 8'h01);
      run(pfci_pkg::OP_READ, 19'h2fff2, 8'h00);
      chk(got, 8'h00);
      run(pfci_pkg::OP_RESET3, 19'h00000, 8'h00);
      run(pfci_pkg::OP_READ, 19'h12345, 8'h00);
      chk(got, 8'hf3);
      run(pfci_pkg::OP_RESET1, 19'h00000, 8'h00);
      w0 = 0;
      while (req_ready !== 1'b1 && w0 < 3000) begin
         tick();
         w0++;
      end
      chk(w0, pfci_pkg::ABORT_CYC);
      run(pfci_pkg::OP_SIG_READ, 19'h00000, 8'h00);
      chk(got, MAKER);
      run(pfci_pkg::OP_SIG_READ, 19'h00001, 8'h00);
      chk(got, PART);
      $display("Test identification finished");
   endtask : t_ident

   task automatic t_prog();
      run(pfci_pkg::OP_PROGRAM, 19'h12345, 8'h0f);
      run(pfci_pkg::OP_READ, 19'h12345, 8'h00);
      chk(got, STAT);
      run(pfci_pkg::OP_IDENT, 19'h00000, 8'h00);
      poll(19'h12345);
      chk(got, 8'h03);
      run(pfci_pkg::OP_PROGRAM, 19'h30010, 8'h00);
      run(pfci_pkg::OP_READ, 19'h30010, 8'h00);
      chk(got, 8'h77);
      run(pfci_pkg::OP_BYPASS, 19'h00000, 8'h00);
      run(pfci_pkg::OP_BYP_PROG, 19'h20000, 8'h5a);
      poll(19'h20000);
      chk(got, 8'h5a);
      run(pfci_pkg::OP_IDENT, 19'h00000, 8'h00);
      run(pfci_pkg::OP_READ, 19'h12345, 8'h00);
      chk(got, 8'h03);
      run(pfci_pkg::OP_BYP_EXIT, 19'h00000, 8'h00);
      run(pfci_pkg::OP_IDENT, 19'h00000, 8'h00);
      run(pfci_pkg::OP_READ, 19'h00000, 8'h00);
      chk(got, MAKER);
      $display("Test program finished");
   endtask : t_prog

   task automatic t_erase();
      run(pfci_pkg::OP_CHIP_ERASE, 19'h00000, 8'h00);
      poll(19'h12345);
      chk(got, 8'hff);
      run(pfci_pkg::OP_READ, 19'h30010, 8'h00);
      chk(got, 8'h77);
      run(pfci_pkg::OP_BLK_ERASE, 19'h20000, 8'h00);
      chk(blk_window, 1'b1);
      w0 = pfci_flash_model_i.nwr;
      run(pfci_pkg::OP_BLK_ADD, 19'h10000, 8'h00);
      chk(pfci_flash_model_i.nwr, w0 + 1);
      run(pfci_pkg::OP_SUSPEND, 19'h00000, 8'h00);
      chk(blk_window, 1'b0);
      w0 = pfci_flash_model_i.nwr;
      run(pfci_pkg::OP_BLK_ADD, 19'h10000, 8'h00);
      chk(pfci_flash_model_i.nwr, w0);
      run(pfci_pkg::OP_RESUME, 19'h00000, 8'h00);
      chk(pfci_flash_model_i.nwr, w0 + 1);
      poll(19'h20000);
      chk(got, 8'hff);
      chk(pfci_flash_model_i.viol, 0);
      $display("Test erase finished");
   endtask : t_erase

   // Main sequence.
   initial begin
      pfci_flash_model_i.mem[32'h12345] = 8'hf3;
      pfci_flash_model_i.mem[32'h30010] = 8'h77;
      repeat (20) tick();
      nrst = 1'b1;
      tick();
      t_ident();
      t_prog();
      t_erase();
      test_done();
   end
endmodule : tb

`default_nettype wire
